/* File: src/iec_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef IEC_REGS_SVH
`define IEC_REGS_SVH

`define IEC_ADDR_W        8
`define IEC_OFS_DEBOUNCE  8'h00
`define IEC_OFS_IRQ_STAT  8'h04
`define IEC_OFS_IRQ_MASK  8'h08
`define IEC_OFS_ALARMS    8'h0c
`define IEC_OFS_CH_BASE   8'h10
`define IEC_CH_STRIDE_LOG 4
`define IEC_OFS_CH_CFG    2'h0
`define IEC_OFS_CH_PRE    2'h1
`define IEC_OFS_CH_CNT    2'h2

`define IEC_CFG_DEB_EN    0
`define IEC_CFG_DOWN      1
`define IEC_CFG_RISE      2
`define IEC_CFG_ALM_EN    3
`define IEC_CFG_LATCH     4
`define IEC_CFG_RETAIN    5
`define IEC_CFG_ALM_CLR   6
`define IEC_CFG_W         6

`define IEC_CFG_RESET     6'h00
`define IEC_DEBOUNCE_RST  16'h0000
`define IEC_CNT_MAX       32'hffffffff

`define IEC_MS_NS         1000000
`define IEC_CLK_NS        8
`define IEC_MS_CYCLES     (`IEC_MS_NS / `IEC_CLK_NS)

`endif

/* File: src/iec_pkg.sv */
// Types shared by the input event counter
package iec_pkg;
  typedef logic [31:0] iec_word_t;
  typedef logic [15:0] iec_ms_t;
endpackage : iec_pkg

/* File: src/iec_ms_tick.sv */
// Millisecond enable pulse from the system clock
`timescale 1ns/100ps
module iec_ms_tick
  import iec_pkg::*;
#(
  parameter int DIV = 125000
)(
  input  wire logic ref_clk,
  input  wire logic rst,
  output logic      ms_tick
);
  logic [31:0] div_cnt;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      div_cnt <= 32'h0;
      ms_tick <= 1'b0;
    end
    else if (div_cnt == 32'(DIV - 1))
    begin
      div_cnt <= 32'h0;
      ms_tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 32'h1;
      ms_tick <= 1'b0;
    end
  end
endmodule : iec_ms_tick

/* File: src/iec_debounce.sv */
// Per-channel debounce filter on a millisecond time base
`timescale 1ns/100ps
module iec_debounce
  import iec_pkg::*;
(
  input  wire logic    ref_clk,
  input  wire logic    rst,
  input  wire logic    ms_tick,
  input  wire logic    enable,
  input  wire iec_ms_t debounce_ms,
  input  wire logic    level_in,
  output logic         level_out
);
  iec_ms_t stable_ms;

  // [R13] Accept after full stable time
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      level_out <= 1'b1;
      stable_ms <= 16'h0000;
    end
    else if (!enable || level_in == level_out)
    begin
      level_out <= level_in;
      stable_ms <= 16'h0000;
    end
    else if (stable_ms >= debounce_ms)
    begin
      level_out <= level_in;
      stable_ms <= 16'h0000;
    end
    else if (ms_tick)
    begin
      stable_ms <= stable_ms + 16'h0001;
    end
  end
endmodule : iec_debounce

/* File: src/iec_top.sv */
// Input event counter bank with register port and alarms
// Function
// [R1] Each channel counts events in 32 bits, optionally retained across reset; a retained count here reloads the preload value on reset
// [R2] Counts events from 0 to 85 Hz; source must not exceed it
// [R3] Per-channel enable selects debounced input for counting
// [R4] One debounce time, 0 to 65535 ms, shared by enabled channels
// [R5] Per-channel direction; up after reset, down decrements from preload
// [R6] Per-channel count edge; falling edge selected after reset
// [R7] Per-channel preload value is the counting start value
// [R8] Rollover or counter reset reloads the preload value
// [R9] Enabled alarm toggles on reaching 0 or all ones
// [R10] Alarm enables cleared after reset
// [R11] Auto mode clears raised alarm on next count
// [R12] Latch mode holds alarm until reset; auto mode is reset default; here alarm disable, a count write or the clear bit also clears it
// [R13] Debounce accepts level after stable for full time in ms
// [R14] Up at all ones or down at zero rolls over to preload
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
`include "iec_regs.svh"
module iec_top
  import iec_pkg::*;
#(
  parameter int NCH       = 4,
  parameter int MS_CYCLES = `IEC_MS_CYCLES
)(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [NCH-1:0]         field_in,
  input  wire logic [`IEC_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  output logic      [NCH-1:0]         alarm_out,
  output logic                        irq
);
  logic                  ms_tick;
  iec_ms_t               debounce_ms;
  logic [NCH-1:0]        irq_stat;
  logic [NCH-1:0]        irq_mask;
  logic [NCH-1:0]        sync_a;
  logic [NCH-1:0]        sync_b;
  logic [NCH-1:0]        filt;
  logic [NCH-1:0]        filt_d;
  logic [NCH-1:0]        alarm_rise;
  logic [NCH-1:0]        ch_sel;
  logic [`IEC_CFG_W-1:0] cfg      [NCH];
  iec_word_t             preload  [NCH];
  iec_word_t             count    [NCH];
  logic [31:0]           next_rdata;
  logic                  glob_hit;
  logic [1:0]            ch_reg;

  assign glob_hit = reg_addr < `IEC_OFS_CH_BASE;
  assign ch_reg   = reg_addr[3:2];

  iec_ms_tick #(
    .DIV (MS_CYCLES)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ms_tick (ms_tick)
  );

  // Two-flop synchronisers on field pins
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync_a <= '1;
      sync_b <= '1;
      filt_d <= '1;
    end
    else
    begin
      sync_a <= field_in;
      sync_b <= sync_a;
      filt_d <= filt;
    end
  end

  // [R4] Shared debounce time
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      debounce_ms <= `IEC_DEBOUNCE_RST;
    else if (reg_wr && reg_addr == `IEC_OFS_DEBOUNCE)
      debounce_ms <= reg_wdata[15:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irq_mask <= '0;
    else if (reg_wr && reg_addr == `IEC_OFS_IRQ_MASK)
      irq_mask <= reg_wdata[NCH-1:0];
  end

  // Sticky alarm events; a new event beats the clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irq_stat <= '0;
    else if (reg_wr && reg_addr == `IEC_OFS_IRQ_STAT)
      irq_stat <= (irq_stat & ~reg_wdata[NCH-1:0]) | alarm_rise;
    else
      irq_stat <= irq_stat | alarm_rise;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_ch
      logic      edge_seen;
      logic      wr_cfg;
      logic      wr_pre;
      logic      wr_cnt;
      iec_word_t next_count;
      logic      rollover;
      logic      at_term;

      assign ch_sel[ch] = reg_addr[`IEC_ADDR_W-1:`IEC_CH_STRIDE_LOG] == (`IEC_ADDR_W-`IEC_CH_STRIDE_LOG)'(ch + 1);
      assign wr_cfg     = reg_wr && ch_sel[ch] && ch_reg == `IEC_OFS_CH_CFG;
      assign wr_pre     = reg_wr && ch_sel[ch] && ch_reg == `IEC_OFS_CH_PRE;
      assign wr_cnt     = reg_wr && ch_sel[ch] && ch_reg == `IEC_OFS_CH_CNT;

      // [R3] Debounce selected per channel
      iec_debounce u_deb (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .ms_tick     (ms_tick),
        .enable      (cfg[ch][`IEC_CFG_DEB_EN]),
        .debounce_ms (debounce_ms),
        .level_in    (sync_b[ch]),
        .level_out   (filt[ch])
      );

      // [R6] Rising or falling count edge
      assign edge_seen = cfg[ch][`IEC_CFG_RISE] ? (filt[ch] & ~filt_d[ch]) : (~filt[ch] & filt_d[ch]);

      // [R14] Wrap past the end reloads preload
      assign rollover = cfg[ch][`IEC_CFG_DOWN] ? (count[ch] == 32'h0) : (count[ch] == `IEC_CNT_MAX);

      // [R5] Up or down step
      always_comb
      begin
        if (rollover)
          next_count = preload[ch];
        else if (cfg[ch][`IEC_CFG_DOWN])
          next_count = count[ch] - 32'h1;
        else
          next_count = count[ch] + 32'h1;
      end

      assign at_term = !rollover && (next_count == 32'h0 || next_count == `IEC_CNT_MAX);

      // [R10] Config clears except retain bit; up, falling, alarm off, auto
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          cfg[ch] <= `IEC_CFG_RESET | {cfg[ch][`IEC_CFG_RETAIN], 5'h00};
        else if (wr_cfg)
          cfg[ch] <= reg_wdata[`IEC_CFG_W-1:0];
      end

      // [R7] Preload value per channel
      always_ff @(posedge ref_clk)
      begin
        if (rst && !cfg[ch][`IEC_CFG_RETAIN])
          preload[ch] <= 32'h0;
        else if (wr_pre)
          preload[ch] <= reg_wdata;
      end

      // [R1] 32-bit count, reloaded from preload on reset when retained
      // [R8] Count write, retained reset or rollover reloads preload
      always_ff @(posedge ref_clk)
      begin
        if (rst && !cfg[ch][`IEC_CFG_RETAIN])
          count[ch] <= 32'h0;
        else if (rst || wr_cnt)
          count[ch] <= preload[ch];
        else if (edge_seen)
          count[ch] <= next_count;
      end

      // [R9] Toggle alarm at terminal value
      // [R11] Auto mode clears on next count
      // [R12] Latch mode holds until reset, alarm disable, count write or a config write with the clear bit
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          alarm_out[ch]  <= 1'b0;
          alarm_rise[ch] <= 1'b0;
        end
        else if (!cfg[ch][`IEC_CFG_ALM_EN] || wr_cnt || (wr_cfg && reg_wdata[`IEC_CFG_ALM_CLR]))
        begin
          alarm_out[ch]  <= 1'b0;
          alarm_rise[ch] <= 1'b0;
        end
        else if (edge_seen && at_term)
        begin
          alarm_out[ch]  <= ~alarm_out[ch];
          alarm_rise[ch] <= ~alarm_out[ch];
        end
        else if (edge_seen && alarm_out[ch] && !cfg[ch][`IEC_CFG_LATCH])
        begin
          alarm_out[ch]  <= 1'b0;
          alarm_rise[ch] <= 1'b0;
        end
        else
          alarm_rise[ch] <= 1'b0;
      end
    end
  endgenerate

  // Read mux; unmapped reads give zero
  always_comb
  begin
    next_rdata = 32'h0;
    if (glob_hit)
    begin
      unique case (reg_addr)
        `IEC_OFS_DEBOUNCE: next_rdata = {16'h0000, debounce_ms};
        `IEC_OFS_IRQ_STAT: next_rdata[NCH-1:0] = irq_stat;
        `IEC_OFS_IRQ_MASK: next_rdata[NCH-1:0] = irq_mask;
        `IEC_OFS_ALARMS:   next_rdata[NCH-1:0] = alarm_out;
        default:           next_rdata = 32'h0;
      endcase
    end
    for (int i = 0; i < NCH; i++)
    begin
      if (ch_sel[i] && reg_addr[1:0] == 2'b00)
      begin
        unique case (ch_reg)
          `IEC_OFS_CH_CFG: next_rdata = {26'h0, cfg[i]};
          `IEC_OFS_CH_PRE: next_rdata = preload[i];
          `IEC_OFS_CH_CNT: next_rdata = count[i];
          default:         next_rdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      reg_rdata <= 32'h0;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 32'h0;
  end
endmodule : iec_top

/* File: tb/iec_checker.sv */
// Port checker for the input event counter
`timescale 1ns/100ps
module iec_checker #(
  parameter int NCH = 4
)(
  input wire logic           ref_clk,
  input wire logic           rst,
  input wire logic [NCH-1:0] field_in,
  input wire logic [7:0]     reg_addr,
  input wire logic [31:0]    reg_wdata,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [31:0]    reg_rdata,
  input wire logic [NCH-1:0] alarm_out,
  input wire logic           irq
);
  logic [3:0] quiet;
  // Cycles since last field change or write
  always_ff @(posedge ref_clk)
  begin
    if (rst || reg_wr || field_in != $past(field_in))
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_reset_quiet: assert property ($past(rst) |-> alarm_out == '0 && !irq)
    else $error("alarm or irq after reset");
  a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h50 |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  a_alarm_readback: assert property (reg_rd && reg_addr == 8'h0c |=> reg_rdata == 32'($past(alarm_out)))
    else $error("alarm register mismatch");
  a_alarm_has_cause: assert property (alarm_out != $past(alarm_out) |-> quiet < 4'h8)
    else $error("alarm moved without count");
  a_irq_has_cause: assert property ($rose(irq) |-> quiet < 4'ha)
    else $error("irq rose without cause");
  a_mask_drops_irq: assert property (reg_wr && reg_addr == 8'h08 && reg_wdata[NCH-1:0] == '0 |-> ##2 !irq)
    else $error("irq stayed with mask off");
  a_stat_clear_irq: assert property (reg_wr && reg_addr == 8'h04 && alarm_out == '0 |-> ##2 !irq)
    else $error("irq stayed after status clear");
  a_latch_clear: assert property (reg_wr && reg_addr == 8'h30 && reg_wdata[6] |-> ##2 !alarm_out[2])
    else $error("latched alarm not cleared");
endmodule : iec_checker

/* File: tb/iec_field_src.sv */
// Field input source, one pulse at a time
`timescale 1ns/100ps
module iec_field_src #(
  parameter int NCH = 4,
  parameter int MS  = 8
)(
  input  wire logic           ref_clk,
  output logic      [NCH-1:0] field_in
);
  initial field_in = '1;
  task automatic pulse(input int ch, input int low_ms);
    @(posedge ref_clk);
    field_in[ch] <= 1'b0;
    repeat (low_ms * MS) @(posedge ref_clk);
    field_in[ch] <= 1'b1;
    repeat (12 * MS) @(posedge ref_clk);
  endtask : pulse
endmodule : iec_field_src

/* File: tb/tb_top.sv */
// Self-checking bench for the input event counter
`timescale 1ns/100ps
module tb_top
  import iec_pkg::*;
;
  logic       ref_clk;
  logic       rst;
  logic       reg_wr;
  logic       reg_rd;
  logic       irq;
  logic [7:0] reg_addr;
  logic [3:0] field_in;
  logic [3:0] alarm_out;
  iec_word_t  reg_wdata;
  iec_word_t  reg_rdata;
  iec_word_t  v;
  int         fail_count;
  int         n_checks;
  iec_top #(.NCH(4), .MS_CYCLES(8)) dut (.ref_clk(ref_clk), .rst(rst), .field_in(field_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .alarm_out(alarm_out), .irq(irq));
  iec_field_src #(.NCH(4), .MS(8)) src (.ref_clk(ref_clk), .field_in(field_in));
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input iec_word_t e, input iec_word_t g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input iec_word_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input iec_word_t e, input string nm);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(nm, e, reg_rdata);
  endtask : rc
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic t_defaults;
    rc(8'h10, 0, "cfg");
    rc(8'h00, 0, "debounce");
    rc(8'h18, 0, "count");
    rc(8'h0c, 0, "alarms");
    rc(8'h50, 0, "unmapped");
    $display("defaults done");
  endtask : t_defaults
  task automatic t_count;
    wr(8'h14, 32'h5);
    wr(8'h18, 32'h0);
    rc(8'h18, 32'h5, "reload");
    src.pulse(0, 1);
    rc(8'h18, 32'h6, "fall count");
    wr(8'h10, 32'h4);
    src.pulse(0, 1);
    rc(8'h18, 32'h7, "rise count");
    $display("count done");
  endtask : t_count
  task automatic t_up_roll;
    wr(8'h08, 32'h2);
    wr(8'h24, 32'hfffffffe);
    wr(8'h28, 32'h0);
    wr(8'h20, 32'h8);
    src.pulse(1, 1);
    rc(8'h28, 32'hffffffff, "up count");
    chk("alarm", 2, alarm_out);
    chk("irq", 1, irq);
    src.pulse(1, 1);
    rc(8'h28, 32'hfffffffe, "up roll");
    chk("auto clear", 0, alarm_out);
    wr(8'h08, 32'h0);
    rc(8'h04, 32'h2, "status");
    chk("irq masked", 0, irq);
    wr(8'h08, 32'h2);
    wr(8'h04, 32'hf);
    rc(8'h04, 32'h0, "status clr");
    chk("irq clr", 0, irq);
    $display("up roll done");
  endtask : t_up_roll
  task automatic t_down_latch;
    wr(8'h34, 32'h1);
    wr(8'h38, 32'h0);
    wr(8'h30, 32'h1a);
    src.pulse(2, 1);
    rc(8'h38, 32'h0, "down count");
    chk("latch set", 4, alarm_out);
    src.pulse(2, 1);
    rc(8'h38, 32'h1, "down roll");
    chk("latch hold", 4, alarm_out);
    chk("irq off", 0, irq);
    wr(8'h30, 32'h5a);
    rc(8'h0c, 32'h0, "latch clr");
    $display("down latch done");
  endtask : t_down_latch
  task automatic t_debounce;
    wr(8'h00, 32'h3);
    wr(8'h40, 32'h1);
    rc(8'h00, 32'h3, "debounce");
    src.pulse(3, 1);
    rc(8'h48, 32'h0, "glitch");
    src.pulse(3, 5);
    rc(8'h48, 32'h1, "stable");
    $display("debounce done");
  endtask : t_debounce
  task automatic t_retain;
    wr(8'h10, 32'h20);
    wr(8'h14, 32'h9);
    wr(8'h18, 32'h0);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rc(8'h18, 32'h9, "retained count");
    rc(8'h10, 32'h20, "retain cfg");
    rc(8'h28, 32'h0, "cleared count");
    chk("alarm rst", 0, alarm_out);
    $display("retain done");
  endtask : t_retain
  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    fail_count = 0;
    n_checks = 0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_defaults();
    t_count();
    t_up_roll();
    t_down_latch();
    t_debounce();
    t_retain();
    report_and_stop();
  end
  initial
  begin
    #200000;
    fail_count++;
    report_and_stop();
  end
endmodule : tb_top
bind iec_top iec_checker #(.NCH(NCH)) chk_i (.ref_clk(ref_clk), .rst(rst), .field_in(field_in),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .alarm_out(alarm_out), .irq(irq));
